// file: pkg/port_mux_defines.svh
`ifndef PORT_MUX_DEFINES_SVH
`define PORT_MUX_DEFINES_SVH

// register word offsets (byte address = offset, all multiples of four)
`define PORT1_LATCH_OFS 8'h90
`define PORT3_LATCH_OFS 8'hb0
`define PORT4_LATCH_OFS 8'hd8
`define PORT1_PINS_OFS 8'h94
`define PORT3_PINS_OFS 8'hb4
`define PORT4_PINS_OFS 8'hdc
`define ALT_CTRL_OFS 8'hc0

// reset values: every latch bit high so all lines come up as inputs
`define PORT_LATCH_RST 8'hff
`define PORT4_LATCH_RST 4'hf
`define ALT_CTRL_RST 8'h00

// alternate control register field positions
`define ALT_PULSE_EN_LO 0
`define ALT_PULSE_EN_HI 4
`define ALT_SER_SYNC_BIT 5
`define ALT_SER_EN_BIT 6
`define ALT_XMEM_EN_BIT 7

// port 1 and 3 bit positions of shared functions
`define P1_PULSE_FIRST 3
`define P3_SER_DATA 0
`define P3_SER_TX 1
`define P3_IRQ_A 2
`define P3_IRQ_B 3
`define P3_TMR_A 4
`define P3_TMR_B 5
`define P3_WR_N 6
`define P3_RD_N 7

// machine cycle: twelve oscillator periods
`define OSC_PER_MCYCLE 12
`define CLK_PERIOD_NS 4

`endif

// file: pkg/port_mux_pkg.sv
package port_mux_pkg;
	typedef logic [7:0] port_byte_t;
	typedef logic [3:0] nibble_t;
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_ACK = 2'b01,
		BUS_DONE = 2'b11
	} bus_state_t;
	typedef enum logic [1:0] {
		SEL_PORT1 = 2'b00,
		SEL_PORT3 = 2'b01,
		SEL_PORT4 = 2'b10
	} port_sel_t;
endpackage

// file: pkg/port_latch_if.sv
`timescale 1ns/1ps
`default_nettype none
interface port_latch_if;
	import port_mux_pkg::*;
	logic wr_en;
	port_sel_t sel;
	port_byte_t wr_data;
	port_byte_t p1_q;
	port_byte_t p3_q;
	nibble_t p4_q;
	modport ctrl (output wr_en, output sel, output wr_data,
		input p1_q, input p3_q, input p4_q);
	modport latch (input wr_en, input sel, input wr_data,
		output p1_q, output p3_q, output p4_q);
endinterface
`default_nettype wire

// file: rtl/port_latch_bank.sv
`timescale 1ns/1ps
`default_nettype none
`include "port_mux_defines.svh"
module port_latch_bank
	import port_mux_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_reset_n,
	port_latch_if.latch lif
);
	port_byte_t p1_r;
	port_byte_t p3_r;
	nibble_t p4_r;
	wire wr_p1 = lif.wr_en && (lif.sel == SEL_PORT1);
	wire wr_p3 = lif.wr_en && (lif.sel == SEL_PORT3);
	wire wr_p4 = lif.wr_en && (lif.sel == SEL_PORT4);

	// the latch output changes on the write edge itself, the edge that raises ack
	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			p1_r <= `PORT_LATCH_RST;
			p3_r <= `PORT_LATCH_RST;
			p4_r <= `PORT4_LATCH_RST;
		end else begin
			if (wr_p1)
				p1_r <= lif.wr_data;
			if (wr_p3)
				p3_r <= lif.wr_data;
			if (wr_p4)
				p4_r <= lif.wr_data[3:0];
		end
	end

	assign lif.p1_q = p1_r;
	assign lif.p3_q = p3_r;
	assign lif.p4_q = p4_r;
endmodule
`default_nettype wire

// file: rtl/port_alt_function_mux.sv
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "port_mux_defines.svh"
module port_alt_function_mux
	import port_mux_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	input wire logic i_wb_rmw,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	input wire logic [7:0] i_port1_bit,
	output logic [7:0] o_port1_bit,
	output logic [7:0] o_port1_bit_oe,
	input wire logic [7:0] i_port3_bit,
	output logic [7:0] o_port3_bit,
	output logic [7:0] o_port3_bit_oe,
	input wire logic [3:0] i_port4_bit,
	output logic [3:0] o_port4_bit,
	output logic [3:0] o_port4_bit_oe,
	input wire logic [4:0] i_pulse_out,
	input wire logic i_ser_data_out,
	input wire logic i_ser_tx_out,
	input wire logic i_xmem_wr_n,
	input wire logic i_xmem_rd_n,
	output logic o_timer2_count_pin,
	output logic o_timer2_aux_pin,
	output logic o_ser_rx_in,
	output logic o_ext_irq_a_pin,
	output logic o_ext_irq_b_pin,
	output logic o_tmr_a_gate,
	output logic o_tmr_b_gate,
	output logic o_tmr_a_count_pin,
	output logic o_tmr_b_count_pin
);
	port_latch_if lif();

	port_latch_bank u_latch (
		.i_clock(i_clock),
		.i_reset_n(i_reset_n),
		.lif(lif)
	);

	bus_state_t state_r;
	bus_state_t state_nxt;
	port_byte_t alt_ctrl_r;
	port_byte_t pin1_r;
	port_byte_t pin3_r;
	nibble_t pin4_r;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;

	// bus decode
	wire req = i_wb_cyc && i_wb_stb;
	wire take = req && (state_r == BUS_IDLE);
	wire wr_lane0 = take && i_wb_we && i_wb_sel[0];
	wire hit_p1 = (i_wb_adr == `PORT1_LATCH_OFS);
	wire hit_p3 = (i_wb_adr == `PORT3_LATCH_OFS);
	wire hit_p4 = (i_wb_adr == `PORT4_LATCH_OFS);
	wire hit_pin1 = (i_wb_adr == `PORT1_PINS_OFS);
	wire hit_pin3 = (i_wb_adr == `PORT3_PINS_OFS);
	wire hit_pin4 = (i_wb_adr == `PORT4_PINS_OFS);
	wire hit_alt = (i_wb_adr == `ALT_CTRL_OFS);
	wire hit_latch = hit_p1 || hit_p3 || hit_p4;

	// alternate control fields
	wire [4:0] pulse_en = alt_ctrl_r[`ALT_PULSE_EN_HI:`ALT_PULSE_EN_LO];
	wire ser_sync = alt_ctrl_r[`ALT_SER_SYNC_BIT];
	wire ser_en = alt_ctrl_r[`ALT_SER_EN_BIT];
	wire xmem_en = alt_ctrl_r[`ALT_XMEM_EN_BIT];

	assign lif.wr_en = wr_lane0 && hit_latch;
	assign lif.sel = hit_p3 ? SEL_PORT3 : (hit_p4 ? SEL_PORT4 : SEL_PORT1);
	assign lif.wr_data = i_wb_dat[7:0];

	// latch reads: rmw accesses see the latch, plain reads see the pins
	wire [7:0] p1_view = i_wb_rmw ? lif.p1_q : pin1_r;
	wire [7:0] p3_view = i_wb_rmw ? lif.p3_q : pin3_r;
	wire [3:0] p4_view = i_wb_rmw ? lif.p4_q : pin4_r;

	always_comb begin
		rdata_nxt = 32'h0000_0000;
		if (hit_p1)
			rdata_nxt = {24'h00_0000, p1_view};
		else if (hit_p3)
			rdata_nxt = {24'h00_0000, p3_view};
		else if (hit_p4)
			rdata_nxt = {28'h000_0000, p4_view};
		else if (hit_pin1)
			rdata_nxt = {24'h00_0000, pin1_r};
		else if (hit_pin3)
			rdata_nxt = {24'h00_0000, pin3_r};
		else if (hit_pin4)
			rdata_nxt = {28'h000_0000, pin4_r};
		else if (hit_alt)
			rdata_nxt = {24'h00_0000, alt_ctrl_r};
	end

	// ack one cycle after take, then a dead cycle so ack drops
	always_comb begin
		case (state_r)
			BUS_IDLE: state_nxt = req ? BUS_ACK : BUS_IDLE;
			BUS_ACK: state_nxt = BUS_DONE;
			BUS_DONE: state_nxt = req ? BUS_DONE : BUS_IDLE;
			default: state_nxt = BUS_IDLE;
		endcase
	end

	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			state_r <= BUS_IDLE;
			rdata_r <= 32'h0000_0000;
		end else begin
			state_r <= state_nxt;
			if (take)
				rdata_r <= rdata_nxt;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_reset_n)
			alt_ctrl_r <= `ALT_CTRL_RST;
		else if (wr_lane0 && hit_alt)
			alt_ctrl_r <= i_wb_dat[7:0];
	end

	// pins are sampled once per clock; anything held a machine cycle
	// (twelve oscillator periods) is therefore always seen
	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			pin1_r <= 8'hff;
			pin3_r <= 8'hff;
			pin4_r <= 4'hf;
		end else begin
			pin1_r <= i_port1_bit;
			pin3_r <= i_port3_bit;
			pin4_r <= i_port4_bit;
		end
	end

	assign o_wb_ack = (state_r == BUS_ACK);
	assign o_wb_dat = rdata_r;

	// alternate output levels: a released function idles high
	logic [7:0] p1_alt;
	logic [7:0] p3_alt;
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_p1
			if (g >= `P1_PULSE_FIRST) begin : g_pwm
				// channel g-3 on bit g, ascending
				assign p1_alt[g] = pulse_en[g - `P1_PULSE_FIRST] ?
					i_pulse_out[g - `P1_PULSE_FIRST] : 1'b1;
			end else begin : g_in
				assign p1_alt[g] = 1'b1;
			end
		end
	endgenerate

	// serial: async drives tx only; sync drives data and shift clock
	assign p3_alt[`P3_SER_DATA] = (ser_en && ser_sync) ?
		i_ser_data_out : 1'b1;
	assign p3_alt[`P3_SER_TX] = ser_en ? i_ser_tx_out : 1'b1;
	assign p3_alt[`P3_IRQ_A] = 1'b1;
	assign p3_alt[`P3_IRQ_B] = 1'b1;
	assign p3_alt[`P3_TMR_A] = 1'b1;
	assign p3_alt[`P3_TMR_B] = 1'b1;
	// strobes only while an external access is enabled
	assign p3_alt[`P3_WR_N] = xmem_en ? i_xmem_wr_n : 1'b1;
	assign p3_alt[`P3_RD_N] = xmem_en ? i_xmem_rd_n : 1'b1;

	// quasi-bidirectional: only the pull-down is driven, a high is the
	// weak pull-up outside, so oe is high exactly when pulling low
	wire [7:0] p1_level = lif.p1_q & p1_alt;
	wire [7:0] p3_level = lif.p3_q & p3_alt;
	assign o_port1_bit = 8'h00;
	assign o_port1_bit_oe = ~p1_level;
	assign o_port3_bit = 8'h00;
	assign o_port3_bit_oe = ~p3_level;
	assign o_port4_bit = 4'h0;
	assign o_port4_bit_oe = ~lif.p4_q;

	// inputs to peripherals come from the synchronous pin samples; they
	// only make sense when software leaves the latch bit at 1
	assign o_timer2_count_pin = pin1_r[0];
	assign o_timer2_aux_pin = pin1_r[1];
	assign o_ser_rx_in = pin3_r[`P3_SER_DATA];
	assign o_ext_irq_a_pin = pin3_r[`P3_IRQ_A];
	assign o_ext_irq_b_pin = pin3_r[`P3_IRQ_B];
	assign o_tmr_a_gate = pin3_r[`P3_IRQ_A];
	assign o_tmr_b_gate = pin3_r[`P3_IRQ_B];
	assign o_tmr_a_count_pin = pin3_r[`P3_TMR_A];
	assign o_tmr_b_count_pin = pin3_r[`P3_TMR_B];
endmodule
`default_nettype wire

// file: verification/port_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module port_pin_model #(parameter int W = 20) (
	input wire logic [W-1:0] i_oe,
	input wire logic [W-1:0] i_ext_low,
	output logic [W-1:0] o_pin
);
	// outside logic only sinks; any pull-down wins over the weak pull-up
	assign o_pin = ~(i_oe | i_ext_low);
endmodule
`default_nettype wire

// file: verification/port_mux_sva.sv
`timescale 1ns/1ps
`default_nettype none
module port_mux_sva (
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	input wire logic o_wb_ack,
	input wire logic [7:0] i_port1_bit,
	input wire logic [7:0] i_port3_bit,
	input wire logic [7:0] o_port1_bit_oe,
	input wire logic [7:0] o_port3_bit_oe,
	input wire logic [3:0] o_port4_bit_oe,
	input wire logic o_timer2_count_pin,
	input wire logic o_timer2_aux_pin,
	input wire logic o_ser_rx_in,
	input wire logic o_ext_irq_a_pin,
	input wire logic o_ext_irq_b_pin,
	input wire logic o_tmr_a_gate,
	input wire logic o_tmr_b_gate,
	input wire logic o_tmr_a_count_pin,
	input wire logic o_tmr_b_count_pin
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_reset_n);
	// inputs pass one sample stage; skip the edge that leaves reset
	property p_t2; $past(i_reset_n) |->
		{o_timer2_aux_pin, o_timer2_count_pin} == $past(i_port1_bit[1:0]);
	endproperty
	a_t2: assert property (p_t2) else $error("timer2 pins");
	property p_rx; $past(i_reset_n) |->
		o_ser_rx_in == $past(i_port3_bit[0]);
	endproperty
	a_rx: assert property (p_rx) else $error("serial rx");
	property p_irq; $past(i_reset_n) |->
		{o_ext_irq_b_pin, o_ext_irq_a_pin, o_tmr_b_gate, o_tmr_a_gate}
		== {2{$past(i_port3_bit[3:2])}};
	endproperty
	a_irq: assert property (p_irq) else $error("irq or gate");
	property p_cnt; $past(i_reset_n) |->
		{o_tmr_b_count_pin, o_tmr_a_count_pin} == $past(i_port3_bit[5:4]);
	endproperty
	a_cnt: assert property (p_cnt) else $error("timer count");
	property p_rst; $rose(i_reset_n) |->
		(o_port1_bit_oe | o_port3_bit_oe) == 8'h00 && o_port4_bit_oe == 4'h0;
	endproperty
	a_rst: assert property (p_rst) else $error("reset oe");
	property p_p4; i_wb_cyc && i_wb_stb && i_wb_we && i_wb_sel[0]
		&& i_wb_adr == 8'hd8 && o_wb_ack |-> o_port4_bit_oe == ~i_wb_dat[3:0];
	endproperty
	a_p4: assert property (p_p4) else $error("port4 write");
	property p_ack; $rose(i_wb_stb) && i_wb_cyc |=> o_wb_ack;
	endproperty
	a_ack: assert property (p_ack) else $error("ack late");
	property p_one; o_wb_ack |=> !o_wb_ack;
	endproperty
	a_one: assert property (p_one) else $error("ack long");
endmodule
bind port_alt_function_mux port_mux_sva port_mux_sva_inst (.*);
`default_nettype wire

// file: verification/port_alt_function_mux_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
	failures++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module port_alt_function_mux_tb_top;
	logic i_clock = 0, i_reset_n = 0, i_wb_cyc = 0, i_wb_stb = 0;
	logic i_wb_we = 0, i_wb_rmw = 0, i_ser_data_out = 1, i_ser_tx_out = 1;
	logic i_xmem_wr_n = 1, i_xmem_rd_n = 1;
	logic [7:0] i_wb_adr = 0;
	logic [3:0] i_wb_sel = 4'h1;
	logic [31:0] i_wb_dat = 0, q;
	logic [4:0] i_pulse_out = 5'h1f;
	logic [19:0] ext_low = 0;
	wire logic [31:0] o_wb_dat;
	wire logic [7:0] i_port1_bit, i_port3_bit, o_port1_bit, o_port3_bit;
	wire logic [7:0] o_port1_bit_oe, o_port3_bit_oe;
	wire logic [3:0] i_port4_bit, o_port4_bit, o_port4_bit_oe;
	wire logic o_wb_ack, o_timer2_count_pin, o_timer2_aux_pin, o_ser_rx_in;
	wire logic o_ext_irq_a_pin, o_ext_irq_b_pin, o_tmr_a_gate, o_tmr_b_gate;
	wire logic o_tmr_a_count_pin, o_tmr_b_count_pin;
	int failures = 0, tests_run = 0;
	port_alt_function_mux port_alt_function_mux_inst (.*);
	port_pin_model port_pin_model_inst (
		.i_oe({o_port4_bit_oe, o_port3_bit_oe, o_port1_bit_oe}),
		.i_ext_low(ext_low),
		.o_pin({i_port4_bit, i_port3_bit, i_port1_bit})
	);
	initial begin
		forever #2 i_clock = ~i_clock;
	end
	task automatic stop_test(input int hung);
		failures += hung;
		$display("failures %0d tests_run %0d", failures, tests_run);
		if (failures == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic wb(input logic w, input logic [7:0] a, d, input logic m);
		int n;
		n = 0;
		i_wb_cyc <= 1'b1;
		i_wb_stb <= 1'b1;
		i_wb_we <= w;
		i_wb_adr <= a;
		i_wb_dat <= {24'h0, d};
		i_wb_rmw <= m;
		do begin
			@(posedge i_clock);
			n++;
		end while (o_wb_ack !== 1'b1 && n < 16);
		if (o_wb_ack !== 1'b1) stop_test(1);
		q = o_wb_dat;
		i_wb_cyc <= 1'b0;
		i_wb_stb <= 1'b0;
		@(posedge i_clock);
	endtask
	task automatic t_reset;
		wb(0, 8'hb0, 0, 1);
		`CHK("p3 latch", 32'hff, q)
		wb(0, 8'hd8, 0, 1);
		`CHK("p4 latch", 32'h0f, q)
		wb(1, 8'h04, 8'h55, 0);
		wb(0, 8'h04, 0, 0);
		`CHK("unmapped", 32'h0, q)
	endtask
	task automatic t_port4;
		wb(1, 8'hd8, 8'ha5, 0);
		`CHK("p4 oe", 4'ha, o_port4_bit_oe)
		`CHK("p4 pin", 4'h5, i_port4_bit)
		i_wb_sel <= 4'h0;
		wb(1, 8'hd8, 8'h00, 0);
		i_wb_sel <= 4'h1;
		wb(0, 8'hd8, 0, 1);
		`CHK("p4 rmw", 32'h05, q)
	endtask
	task automatic t_pins;
		ext_low <= 20'h01d01;
		repeat (13) @(posedge i_clock);
		wb(0, 8'hb0, 0, 0);
		`CHK("p3 pins", 32'he2, q)
		wb(0, 8'hb0, 0, 1);
		`CHK("p3 rmw", 32'hff, q)
		`CHK("t2", 2'b10, {o_timer2_aux_pin, o_timer2_count_pin})
		`CHK("rx", 1'b0, o_ser_rx_in)
		`CHK("irq", 2'b00, {o_ext_irq_b_pin, o_tmr_a_gate})
		`CHK("cnt", 2'b10, {o_tmr_b_count_pin, o_tmr_a_count_pin})
		ext_low <= 20'h0;
	endtask
	task automatic t_alt1;
		i_pulse_out <= 5'h0a;
		wb(1, 8'hc0, 8'h1f, 0);
		`CHK("p1 alt", 8'ha8, o_port1_bit_oe)
		wb(1, 8'h90, 8'hfa, 0);
		`CHK("p1 mix", 8'had, o_port1_bit_oe)
		wb(1, 8'hc0, 8'h00, 0);
		`CHK("p1 latch", 8'h05, o_port1_bit_oe)
	endtask
	task automatic t_alt3;
		wb(1, 8'hb0, 8'h7f, 0);
		`CHK("p3 low", 8'h80, o_port3_bit_oe)
		wb(1, 8'hb0, 8'hff, 0);
		i_ser_data_out <= 1'b0;
		i_xmem_wr_n <= 1'b0;
		wb(1, 8'hc0, 8'he0, 0);
		`CHK("p3 sync", 8'h41, o_port3_bit_oe)
		i_ser_tx_out <= 1'b0;
		wb(1, 8'hc0, 8'h40, 0);
		`CHK("p3 async", 8'h02, o_port3_bit_oe)
	endtask
	// pin-only views, control readback, read strobe and a mid-run reset
	task automatic t_views;
		ext_low <= 20'h80c02;
		i_xmem_rd_n <= 1'b0;
		wb(1, 8'hc0, 8'h80, 0);
		`CHK("p3 oe rd", 8'hc0, o_port3_bit_oe)
		wb(0, 8'hb4, 0, 0);
		`CHK("p3 pin view", 32'h33, q)
		wb(0, 8'h94, 0, 0);
		`CHK("p1 pin view", 32'hf8, q)
		wb(0, 8'hdc, 0, 0);
		`CHK("p4 pin view", 32'h05, q)
		wb(0, 8'hc0, 0, 0);
		`CHK("alt readback", 32'h80, q)
		`CHK("drive lvl", 20'h0, {o_port4_bit, o_port3_bit, o_port1_bit})
		i_reset_n <= 1'b0;
		repeat (2) @(posedge i_clock);
		i_reset_n <= 1'b1;
		@(posedge i_clock);
		`CHK("rst oe", 20'h0, {o_port4_bit_oe, o_port3_bit_oe, o_port1_bit_oe})
		ext_low <= 20'h0;
		i_xmem_rd_n <= 1'b1;
		i_xmem_wr_n <= 1'b1;
		wb(0, 8'hb0, 0, 1);
		`CHK("p3 after rst", 32'hff, q)
	endtask
	initial begin
		repeat (8) @(posedge i_clock);
		i_reset_n <= 1'b1;
		@(posedge i_clock);
		t_reset;
		t_port4;
		t_pins;
		t_alt1;
		t_alt3;
		t_views;
		stop_test(0);
	end
endmodule
`default_nettype wire
